/* design/current_measure_postproc.sv */
// Current reading trim, compensation, saturation, average and logs
// What this block does
// RULE1: Average current over 0.7 s to 6.4 h
// RULE2: First sample after wake seeds the average
// RULE3: Each sample above logged max or below logged min replaces it
// RULE4: Power-up peak log is 0x807f
// RULE5: Host write of 0x807f clears peak log
// RULE6: Max in upper byte, min lower, signed
// RULE7: Peak log reinitialised after each save
// RULE8: Save copies log to backup, never restores
// RULE9: Current is raw times gain/256 plus offset
// RULE10: Trim holds gain high, offset -32..+31 low
// RULE11: Gain is signed, 0x100 means unity
// RULE12: Host should keep trim at 0x4000
// RULE13: Compensate only if enabled, fast mode off
// RULE14: Coefficient spans 0 to 3.1224 %/C
// RULE15: Reset loads backup coefficient or copper default
// RULE16: Host never enables fast and compensation together
// RULE17: Copper sensing needs custom conversion bit clear
// RULE18: Track minimum discharge in 45 s window
// RULE19: Window minimum starts zero, host clears it
// RULE20: Current saturates to signed 16-bit range
// RULE21: Sample every 351.5 ms, hibernate scaled
// RULE22: Peak compare uses current upper byte
`timescale 1ns/1ps
`include "cmeas_cfg.svh"

module current_measure_postproc
    import cmeas_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = `CM_SAMPLE_CYC,
    parameter int unsigned WINDOW_CYC = `CM_WINDOW_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Converter and temperature
    input  wire word_t       raw_sample,
    input  wire word_t       die_temp,
    // Operating mode
    input  wire logic        active_mode,
    input  wire logic [2:0]  low_power_cfg,
    input  wire logic [3:0]  filter_cfg,
    // Configuration bits
    input  wire logic        fast_conversion_enable,
    input  wire logic        sense_temp_comp_enable,
    input  wire logic        custom_coeff_enable,
    input  wire logic        custom_conversion_cfg_enable,
    input  wire logic        peak_log_save_enable,
    input  wire logic        nv_save_req,
    // Register port
    input  wire logic [8:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_rvalid,
    // Results
    output word_t            current_value,
    output logic             current_update,
    output word_t            averaged_current
);

    logic [22:0]        tick_cnt_q, tick_cnt_d;
    logic [2:0]         hib_cnt_q, hib_cnt_d;
    logic [29:0]        win_cnt_q, win_cnt_d;
    logic               tick, win_end;
    pstate_e            st_q, st_d;
    word_t              raw_q, raw_d;
    logic signed [18:0] sc_q, sc_d;
    logic signed [21:0] comp_q, comp_d;
    word_t              cur_q, cur_d, cur_new;
    logic               upd_q, upd_d;
    logic [15:0]        peak_q, peak_d, peak_bk_q, peak_bk_d, peak_base;
    word_t              min_q, min_d, min_base;
    logic [15:0]        tco_q, tco_d, tco_bk_q, tco_bk_d;
    logic [15:0]        trim_q, trim_d;
    logic               boot_q, boot_d, seed_q, seed_d, act_q;
    logic [15:0]        rdata_q, rdata_d;
    logic               rvalid_q;
    logic signed [9:0]  gain;
    logic signed [5:0]  offs;
    logic signed [25:0] gprod;
    logic signed [16:0] dtemp;
    logic signed [65:0] corr_prod;
    logic signed [21:0] corr;
    logic               comp_on;
    logic signed [7:0]  cbyte;

    function automatic logic wr_hit(input logic we, input logic [8:0] a, input logic [8:0] t);
        return we && (a == t);
    endfunction

    function automatic word_t sat16(input logic signed [21:0] v);
        if (v > 22'sh007fff) begin
            return 16'sh7fff;
        end else if (v < -22'sh008000) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction

    // RULE21: sample pacing
    assign tick    = (tick_cnt_q == 23'(SAMPLE_CYC - 1)) &&
                     (active_mode || hib_cnt_q >= low_power_cfg);
    assign win_end = (win_cnt_q == 30'(WINDOW_CYC - 1));

    // RULE10: trim fields
    // RULE11: signed gain field
    assign gain  = trim_q[`CM_GAIN_MSB:`CM_GAIN_LSB];
    assign offs  = trim_q[`CM_OFF_MSB:`CM_OFF_LSB];
    // RULE9: scale by signed gain over 256
    assign gprod = raw_q * gain;
    assign dtemp = $signed({die_temp[15], die_temp}) - $signed(`CM_TEMP_REF);
    // RULE14: coefficient as unsigned span fraction
    assign corr_prod = sc_q * $signed({1'b0, tco_q}) * dtemp * $signed(13'(`CM_TC_MULT));
    assign corr      = 22'(corr_prod >>> `CM_TC_SHIFT);
    // RULE13: compensation gate
    // RULE17: copper sensing with default conversion setup
    assign comp_on = !fast_conversion_enable && sense_temp_comp_enable &&
                     !custom_conversion_cfg_enable;
    // RULE20: clamp to word range
    assign cur_new = sat16(comp_q);
    // RULE22: peak compare on upper byte
    assign cbyte   = cur_new[15:8];

    always_comb begin
        tick_cnt_d = tick_cnt_q + 23'h000001;
        hib_cnt_d  = hib_cnt_q;
        if (tick_cnt_q == 23'(SAMPLE_CYC - 1)) begin
            tick_cnt_d = 23'h000000;
            hib_cnt_d  = tick ? 3'h0 : hib_cnt_q + 3'h1;
        end
        win_cnt_d = win_end ? 30'h00000000 : win_cnt_q + 30'h00000001;
        st_d   = st_q;
        raw_d  = raw_q;
        sc_d   = sc_q;
        comp_d = comp_q;
        cur_d  = cur_q;
        upd_d  = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                if (tick) begin
                    raw_d = raw_sample;
                    st_d  = ST_SCALE;
                end
            end
            ST_SCALE: begin
                sc_d = 19'(gprod >>> `CM_GAIN_FRAC) + 19'(offs);
                st_d = ST_COMP;
            end
            ST_COMP: begin
                comp_d = comp_on ? 22'(sc_q) - corr : 22'(sc_q);
                st_d   = ST_STORE;
            end
            ST_STORE: begin
                cur_d = cur_new;
                upd_d = 1'b1;
                st_d  = ST_IDLE;
            end
        endcase

        // RULE5: host write clears, sample still lands
        // RULE7: reinitialise after each save
        if (wr_hit(reg_wr, reg_addr, `CM_ADDR_PEAK_LOG)) begin
            peak_base = reg_wdata;
        end else if (nv_save_req) begin
            peak_base = `CM_PEAK_INIT;
        end else begin
            peak_base = peak_q;
        end
        peak_d = peak_base;
        // RULE3: replace max or min
        // RULE6: max upper byte, min lower byte
        if (st_q == ST_STORE) begin
            if (cbyte > $signed(peak_base[`CM_PEAK_MAX_MSB:`CM_PEAK_MAX_LSB])) begin
                peak_d[`CM_PEAK_MAX_MSB:`CM_PEAK_MAX_LSB] = cbyte;
            end
            if (cbyte < $signed(peak_base[`CM_PEAK_MIN_MSB:`CM_PEAK_MIN_LSB])) begin
                peak_d[`CM_PEAK_MIN_MSB:`CM_PEAK_MIN_LSB] = cbyte;
            end
        end
        // RULE8: one-way copy to backup
        peak_bk_d = peak_bk_q;
        if (nv_save_req && peak_log_save_enable) begin
            peak_bk_d = peak_q;
        end else if (wr_hit(reg_wr, reg_addr, `CM_ADDR_PEAK_BK)) begin
            peak_bk_d = reg_wdata;
        end

        // RULE19: host write or window end restarts
        if (wr_hit(reg_wr, reg_addr, `CM_ADDR_MIN_DIS)) begin
            min_base = reg_wdata;
        end else if (win_end) begin
            min_base = `CM_MIN_DIS_INIT;
        end else begin
            min_base = min_q;
        end
        // RULE18: keep smaller reading
        min_d = min_base;
        if (st_q == ST_STORE && cur_new < min_base) begin
            min_d = cur_new;
        end

        trim_d = wr_hit(reg_wr, reg_addr, `CM_ADDR_TRIM) ? reg_wdata : trim_q;
        tco_bk_d = wr_hit(reg_wr, reg_addr, `CM_ADDR_TEMPCO_BK) ? reg_wdata : tco_bk_q;
        // RULE15: load coefficient after reset
        boot_d = 1'b0;
        if (boot_q) begin
            tco_d = custom_coeff_enable ? tco_bk_q : `CM_TEMPCO_DEF;
        end else if (wr_hit(reg_wr, reg_addr, `CM_ADDR_TEMPCO)) begin
            tco_d = reg_wdata;
        end else begin
            tco_d = tco_q;
        end

        // RULE2: wake edge arms the seed, set wins
        seed_d = (active_mode && !act_q) || (seed_q && st_q != ST_STORE);

        unique case (reg_addr)
            `CM_ADDR_PEAK_LOG:  rdata_d = peak_q;
            `CM_ADDR_CURRENT:   rdata_d = cur_q;
            `CM_ADDR_AVERAGE:   rdata_d = averaged_current;
            `CM_ADDR_MIN_DIS:   rdata_d = min_q;
            `CM_ADDR_TEMPCO:    rdata_d = tco_q;
            `CM_ADDR_PEAK_BK:   rdata_d = peak_bk_q;
            `CM_ADDR_TRIM:      rdata_d = trim_q;
            `CM_ADDR_TEMPCO_BK: rdata_d = tco_bk_q;
            default:            rdata_d = 16'h0000;
        endcase
        if (!reg_rd) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tick_cnt_q <= 23'h000000;
            hib_cnt_q  <= 3'h0;
            win_cnt_q  <= 30'h00000000;
            st_q       <= ST_IDLE;
            raw_q      <= 16'sh0000;
            sc_q       <= 19'sh00000;
            comp_q     <= 22'sh000000;
            cur_q      <= 16'sh0000;
            upd_q      <= 1'b0;
            // RULE4: power-up peak pattern
            peak_q     <= `CM_PEAK_INIT;
            peak_bk_q  <= `CM_PEAK_INIT;
            min_q      <= `CM_MIN_DIS_INIT;
            tco_q      <= `CM_TEMPCO_DEF;
            tco_bk_q   <= `CM_TEMPCO_DEF;
            trim_q     <= `CM_TRIM_DEF;
            boot_q     <= 1'b1;
            seed_q     <= 1'b1;
            act_q      <= 1'b0;
            rdata_q    <= 16'h0000;
            rvalid_q   <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            hib_cnt_q  <= hib_cnt_d;
            win_cnt_q  <= win_cnt_d;
            st_q       <= st_d;
            raw_q      <= raw_d;
            sc_q       <= sc_d;
            comp_q     <= comp_d;
            cur_q      <= cur_d;
            upd_q      <= upd_d;
            peak_q     <= peak_d;
            peak_bk_q  <= peak_bk_d;
            min_q      <= min_d;
            tco_q      <= tco_d;
            tco_bk_q   <= tco_bk_d;
            trim_q     <= trim_d;
            boot_q     <= boot_d;
            seed_q     <= seed_d;
            act_q      <= active_mode;
            rdata_q    <= rdata_d;
            rvalid_q   <= reg_rd;
        end
    end

    // RULE1: selectable averaging span
    current_avg_filter u_avg (
        .mclk         (mclk),
        .srst         (srst),
        .sample_valid (st_q == ST_STORE),
        .seed         (seed_q),
        .sample       (cur_new),
        .span_sel     (filter_cfg),
        .avg_value    (averaged_current)
    );

    assign reg_rdata      = rdata_q;
    assign reg_rvalid     = rvalid_q;
    assign current_value  = cur_q;
    assign current_update = upd_q;

    chk_tick_to_update: assert property ( // RULE21
        @(posedge mclk) disable iff (srst) tick |-> ##4 current_update)
        else $error("update did not follow tick by four cycles");

    chk_peak_bounds: assert property ( // RULE3
        @(posedge mclk) disable iff (srst)
        st_q == ST_STORE |=> ($signed(peak_q[15:8]) >= $signed(cur_q[15:8])) &&
                             ($signed(peak_q[7:0]) <= $signed(cur_q[15:8])))
        else $error("peak log does not bracket new sample");

    chk_save_reinit: assert property ( // RULE7
        @(posedge mclk) disable iff (srst)
        nv_save_req && !reg_wr && st_q != ST_STORE |=> peak_q == `CM_PEAK_INIT)
        else $error("peak log not reinitialised after save");

    chk_backup_copy: assert property ( // RULE8
        @(posedge mclk) disable iff (srst)
        nv_save_req && peak_log_save_enable |=> peak_bk_q == $past(peak_q))
        else $error("backup does not hold saved log");

    chk_min_track: assert property ( // RULE18
        @(posedge mclk) disable iff (srst) st_q == ST_STORE |=> min_q <= cur_q)
        else $error("window minimum above latest current");

    chk_boot_coeff: assert property ( // RULE15
        @(posedge mclk) disable iff (srst)
        boot_q |=> tco_q == ($past(custom_coeff_enable) ? $past(tco_bk_q) : `CM_TEMPCO_DEF))
        else $error("coefficient not loaded after reset");

    chk_gain_unity: assert property ( // RULE9
        @(posedge mclk) disable iff (srst)
        st_q == ST_SCALE && trim_q == `CM_TRIM_DEF |=> sc_q == 19'($past(raw_q)))
        else $error("unity trim changed the reading");

    chk_comp_off: assert property ( // RULE13
        @(posedge mclk) disable iff (srst)
        st_q == ST_COMP && !comp_on |=> comp_q == 22'($past(sc_q)))
        else $error("compensation applied while disabled");

    chk_sat_high: assert property ( // RULE20
        @(posedge mclk) disable iff (srst)
        st_q == ST_STORE && comp_q > 22'sh007fff |=> cur_q == 16'sh7fff)
        else $error("positive overrange not clamped");

    chk_seed_avg: assert property ( // RULE2
        @(posedge mclk) disable iff (srst)
        st_q == ST_STORE && seed_q |=> averaged_current == cur_q)
        else $error("average not seeded by first sample");

endmodule // current_measure_postproc

/* design/cmeas_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CMEAS_CFG_SVH
`define CMEAS_CFG_SVH

`define CM_ADDR_PEAK_LOG    9'h00a
`define CM_ADDR_CURRENT     9'h01c
`define CM_ADDR_AVERAGE     9'h01d
`define CM_ADDR_MIN_DIS     9'h0ae
`define CM_ADDR_TEMPCO      9'h0b8
`define CM_ADDR_PEAK_BK     9'h1ab
`define CM_ADDR_TRIM        9'h1c8
`define CM_ADDR_TEMPCO_BK   9'h1c9

`define CM_PEAK_INIT        16'h807f
`define CM_MIN_DIS_INIT     16'h0000
`define CM_TEMPCO_DEF       16'h20c8
`define CM_TRIM_DEF         16'h4000

`define CM_PEAK_MAX_MSB     15
`define CM_PEAK_MAX_LSB     8
`define CM_PEAK_MIN_MSB     7
`define CM_PEAK_MIN_LSB     0
`define CM_GAIN_MSB         15
`define CM_GAIN_LSB         6
`define CM_OFF_MSB          5
`define CM_OFF_LSB          0
`define CM_GAIN_FRAC        8

`define CM_TEMP_REF         17'h01900
`define CM_TC_SPAN_PPM      31224
`define CM_TC_MULT          ((`CM_TC_SPAN_PPM * 65536) / 1000000)
`define CM_TC_SHIFT         40

`define CM_CLK_MHZ          20
`define CM_SAMPLE_US        351500
`define CM_SAMPLE_CYC       (`CM_SAMPLE_US * `CM_CLK_MHZ)
`define CM_WINDOW_S         45
`define CM_WINDOW_CYC       (`CM_WINDOW_S * `CM_CLK_MHZ * 1000000)

`define CM_AVG_FRAC         16

`endif

/* design/cmeas_pkg.sv */
// Types shared by the current post-processing design
package cmeas_pkg;

    typedef logic signed [15:0] word_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SCALE = 2'b01,
        ST_COMP  = 2'b10,
        ST_STORE = 2'b11
    } pstate_e;

endpackage

/* design/current_avg_filter.sv */
// Exponential average of the stored current with seed on request
`timescale 1ns/1ps
`include "cmeas_cfg.svh"

module current_avg_filter
    import cmeas_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Sample in
    input  wire logic        sample_valid,
    input  wire logic        seed,
    input  wire word_t       sample,
    input  wire logic [3:0]  span_sel,
    // Average out
    output word_t            avg_value
);

    logic signed [31:0] acc_q;
    logic signed [31:0] acc_d;
    logic signed [32:0] diff;
    logic signed [32:0] step;

    always_comb begin
        diff  = 33'($signed({sample, 16'h0000})) - 33'(acc_q);
        step  = diff >>> ({1'b0, span_sel} + 5'h01);
        acc_d = acc_q;
        if (sample_valid) begin
            if (seed) begin
                acc_d = {sample, 16'h0000};
            end else begin
                acc_d = acc_q + 32'(step);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            acc_q <= 32'sh00000000;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign avg_value = acc_q[31:`CM_AVG_FRAC];

endmodule // current_avg_filter

/* verification/sense_source.sv */
// Sense resistor and host configuration model facing the converter side
`timescale 1ns/1ps

module sense_source
    import cmeas_pkg::*;
(
    // Requests from the bench
    input  wire word_t  want,
    input  wire word_t  temp_in,
    input  wire logic   fast_req,
    input  wire logic   comp_req,
    // Converter and configuration outputs
    output word_t       raw_sample,
    output word_t       die_temp,
    output logic        fast_conversion_enable,
    output logic        sense_temp_comp_enable
);
    assign raw_sample = want;
    assign die_temp   = temp_in;
    assign fast_conversion_enable = fast_req & ~comp_req;
    assign sense_temp_comp_enable = comp_req;
endmodule // sense_source

/* verification/testbench.sv */
// Register level tests of the current post-processing block
`timescale 1ns/1ps
`include "cmeas_cfg.svh"

module testbench
    import cmeas_pkg::*;
;
    localparam int SC = 32;
    localparam int WC = 4000;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    word_t       want = 16'h0000;
    word_t       temp = 16'h1900;
    logic        fast_req = 1'b0;
    logic        comp_req = 1'b0;
    logic        active_mode = 1'b1;
    logic [2:0]  low_power_cfg = 3'h0;
    logic [3:0]  filter_cfg = 4'h0;
    logic        custom_coeff_enable = 1'b0;
    logic        custom_conversion_cfg_enable = 1'b0;
    logic        peak_log_save_enable = 1'b0;
    logic        nv_save_req = 1'b0;
    logic [8:0]  reg_addr = 9'h000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    word_t       raw_sample, die_temp, current_value, averaged_current;
    logic        fast_conversion_enable, sense_temp_comp_enable, current_update;
    int          miscompares = 0;
    int          total_checks = 0;
    int          n;
    longint      e;

    always #25 mclk = ~mclk;

    sense_source i_src (.want(want), .temp_in(temp), .fast_req(fast_req), .comp_req(comp_req),
        .raw_sample(raw_sample), .die_temp(die_temp),
        .fast_conversion_enable(fast_conversion_enable),
        .sense_temp_comp_enable(sense_temp_comp_enable));

    current_measure_postproc #(.SAMPLE_CYC(SC), .WINDOW_CYC(WC)) i_dut (
        .mclk(mclk), .srst(srst), .raw_sample(raw_sample), .die_temp(die_temp),
        .active_mode(active_mode), .low_power_cfg(low_power_cfg), .filter_cfg(filter_cfg),
        .fast_conversion_enable(fast_conversion_enable),
        .sense_temp_comp_enable(sense_temp_comp_enable),
        .custom_coeff_enable(custom_coeff_enable),
        .custom_conversion_cfg_enable(custom_conversion_cfg_enable),
        .peak_log_save_enable(peak_log_save_enable), .nv_save_req(nv_save_req),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .current_value(current_value),
        .current_update(current_update), .averaged_current(averaged_current));

    task tick;
        @(posedge mclk);
        #1;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t value %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [8:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask

    task rchk(input logic [8:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick;
        reg_rd = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk(reg_rdata, exp);
        tick;
    endtask

    // Waits for the next result pulse, n counts the cycles
    task wpulse;
        n = 0;
        do begin
            tick;
            n++;
        end while (current_update !== 1'b1 && n < 8 * SC);
        chk({15'h0000, current_update}, 16'h0001);
    endtask

    task smp(input word_t v);
        want = v;
        wpulse;
    endtask

    task save(input logic en);
        peak_log_save_enable = en;
        nv_save_req = 1'b1;
        tick;
        nv_save_req = 1'b0;
    endtask

    task done(input string s);
        $display("test %s done", s);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        give_verdict;
    end

    initial begin
        repeat (10) tick;
        srst = 1'b0;
        rchk(`CM_ADDR_PEAK_LOG, `CM_PEAK_INIT);
        rchk(`CM_ADDR_MIN_DIS, 16'h0000);
        rchk(`CM_ADDR_TEMPCO, 16'h20c8);
        rchk(`CM_ADDR_TEMPCO_BK, 16'h20c8);
        rchk(`CM_ADDR_PEAK_BK, 16'h807f);
        rchk(`CM_ADDR_TRIM, 16'h4000);
        rchk(9'h1ff, 16'h0000);
        wpulse;
        done("reset");
        smp(16'h1234);
        chk(current_value, 16'h1234);
        rchk(`CM_ADDR_AVERAGE, 16'h091a);
        smp(16'h8500);
        rchk(`CM_ADDR_PEAK_LOG, 16'h1285);
        chk(averaged_current, 16'hc70d);
        rchk(`CM_ADDR_MIN_DIS, 16'h8500);
        wr(`CM_ADDR_CURRENT, 16'h0000);
        rchk(`CM_ADDR_CURRENT, 16'h8500);
        wr(`CM_ADDR_MIN_DIS, 16'h0000);
        rchk(`CM_ADDR_MIN_DIS, 16'h0000);
        done("logs");
        wr(`CM_ADDR_TRIM, 16'h2005);
        smp(16'h1000);
        chk(current_value, 16'h0805);
        wr(`CM_ADDR_TRIM, 16'hc020);
        smp(16'h0100);
        chk(current_value, 16'hfee0);
        wr(`CM_ADDR_TRIM, 16'h7fc0);
        smp(16'h7000);
        chk(current_value, 16'h7fff);
        smp(16'h9000);
        chk(current_value, 16'h8000);
        wr(`CM_ADDR_TRIM, `CM_TRIM_DEF);
        done("trim");
        wr(`CM_ADDR_PEAK_LOG, 16'h807f);
        rchk(`CM_ADDR_PEAK_LOG, 16'h807f);
        smp(16'h0300);
        rchk(`CM_ADDR_PEAK_LOG, 16'h0303);
        save(1'b1);
        rchk(`CM_ADDR_PEAK_LOG, 16'h807f);
        rchk(`CM_ADDR_PEAK_BK, 16'h0303);
        smp(16'h0500);
        rchk(`CM_ADDR_PEAK_LOG, 16'h0505);
        save(1'b0);
        rchk(`CM_ADDR_PEAK_LOG, 16'h807f);
        rchk(`CM_ADDR_PEAK_BK, 16'h0303);
        done("save");
        temp = 16'h2300;
        fast_req = 1'b1;
        smp(16'h1000);
        chk(current_value, 16'h1000);
        comp_req = 1'b1;
        custom_conversion_cfg_enable = 1'b1;
        smp(16'h1000);
        chk(current_value, 16'h1000);
        custom_conversion_cfg_enable = 1'b0;
        smp(16'h1000);
        e = 4096 - ((longint'(4096) * 16'h20c8 * 2560 * 2046) >>> 40);
        chk(current_value, e[15:0]);
        wr(`CM_ADDR_TEMPCO, 16'h4190);
        smp(16'h1000);
        e = 4096 - ((longint'(4096) * 16'h4190 * 2560 * 2046) >>> 40);
        chk(current_value, e[15:0]);
        comp_req = 1'b0;
        fast_req = 1'b0;
        temp = 16'h1900;
        done("compensation");
        active_mode = 1'b0;
        low_power_cfg = 3'h1;
        wpulse;
        wpulse;
        wpulse;
        chk(n[15:0], 16'(2 * SC));
        active_mode = 1'b1;
        smp(16'h0400);
        chk(averaged_current, 16'h0400);
        smp(16'h0800);
        chk(averaged_current, 16'h0600);
        filter_cfg = 4'h3;
        smp(16'h1600);
        chk(averaged_current, 16'h0700);
        chk(n[15:0], 16'(SC));
        done("average");
        wr(`CM_ADDR_MIN_DIS, 16'h0000);
        smp(16'h8800);
        rchk(`CM_ADDR_MIN_DIS, 16'h8800);
        smp(16'h0100);
        rchk(`CM_ADDR_MIN_DIS, 16'h8800);
        repeat (WC) tick;
        rchk(`CM_ADDR_MIN_DIS, 16'h0000);
        done("window");
        custom_coeff_enable = 1'b1;
        srst = 1'b1;
        repeat (2) tick;
        srst = 1'b0;
        rchk(`CM_ADDR_PEAK_LOG, 16'h807f);
        rchk(`CM_ADDR_TEMPCO, 16'h20c8);
        rchk(`CM_ADDR_MIN_DIS, 16'h0000);
        done("rereset");
        give_verdict;
    end
endmodule // testbench
